// file: common/ecx_cfg.svh
// constants of the execute core
`ifndef ECX_CFG_SVH
`define ECX_CFG_SVH
// ==========================================
// register map
`define ECX_ADDR_W    12
`define ECX_CMD_OFS   12'h000
`define ECX_STAT_OFS  12'h004
`define ECX_PC_OFS    12'h008
`define ECX_DATA_SEL  2'h1
`define ECX_RESP_OK   2'h0
`define ECX_RESP_ERR  2'h2
// ==========================================
// data space layout
`define ECX_BITIO_MAX 8'h1F
`define ECX_PORT_MAX  8'h3F
`define ECX_IO_OFS    8'h20
`define ECX_FLAG_DA   8'h36
`define ECX_R0        8'h00
`define ECX_R1        8'h01
`define ECX_ZL        8'h1E
`define ECX_ZH        8'h1F
`define ECX_PAIR_HI   2'h3
`define ECX_ALL_ONES  8'hFF
`define ECX_SP_RST    8'hFF
`define ECX_PC_RST    16'h0000
`define ECX_PC_STEP   16'h0001
`define ECX_PC_SKIPS  16'h0002
`define ECX_PC_SKIPL  16'h0003
`define ECX_SP_STEP   8'h02
// ==========================================
// status bit positions
`define ECX_SR_C 0
`define ECX_SR_Z 1
`define ECX_SR_N 2
`define ECX_SR_V 3
`define ECX_SR_S 4
`define ECX_SR_H 5
// ==========================================
// clocks per instruction
`define ECX_T_ALU   4'h1
`define ECX_T_WORD  4'h2
`define ECX_T_MUL   4'h2
`define ECX_T_JUMP_VIA_Z  4'h2
`define ECX_T_SUBROUTINE_VIA_Z 4'h3
`define ECX_T_BITOP 4'h2
`define ECX_T_LDST  4'h2
`define ECX_T_SKIPS 4'h2
`define ECX_T_SKIPL 4'h3
`endif

// file: common/ecx_pkg.sv
// types of the execute core
package ecx_pkg;
  `include "ecx_cfg.svh"
  typedef enum logic [4:0] {
    op_nop, op_add_with_carry, op_word_sum_immediate, op_word_sub_immediate,
    op_sub_with_borrow, op_sub_constant, op_sub_borrow_constant,
    op_conj_constant, op_disj_constant, op_bits_set_mask, op_bits_clear_mask,
    op_zero_minus_test, op_product_unsigned, op_product_signed, op_product_mixed,
    op_fractional_product_unsigned, op_fractional_product_signed,
    op_fractional_product_mixed, op_jump_via_z, op_subroutine_via_z,
    op_compare_skip_equal, op_io_bit_set, op_io_bit_clear, op_skip_io_bit_high,
    op_skip_io_bit_low, op_port_read, op_port_write, op_read_mem_direct,
    op_write_mem_direct
  } ecx_op_t;
  typedef struct packed {
    logic [7:0] imm;
    logic [1:0] rsv_b;
    logic       long_next;
    logic [4:0] rr;
    logic [2:0] rsv_a;
    logic [4:0] rd;
    logic [2:0] bsel;
    ecx_op_t    op;
  } ecx_cmd_t;
  typedef struct packed {
    logic [255:0][7:0]       mem;
    logic [15:0]             pc;
    logic [7:0]              sreg;
    logic [7:0]              sp;
    logic [3:0]              cnt;
    logic                    err;
    logic                    skip;
    logic [31:0]             cmd;
    logic                    aw_ok;
    logic                    w_ok;
    logic [`ECX_ADDR_W-1:0]  awa;
    logic [31:0]             wd;
    logic                    ws0;
    logic                    bv;
    logic [1:0]              br;
    logic                    rv;
    logic [31:0]             rdat;
    logic [1:0]              rr;
  } ecx_state_t;
endpackage

// file: logic/ecx_core.sv
// execute core with axi4-lite command and data access
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ecx_cfg.svh"
module ecx_core
  import ecx_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // axi4-lite write
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`ECX_ADDR_W-1:0] awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // axi4-lite read
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [`ECX_ADDR_W-1:0] araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // peripheral status events and core busy
  input  wire logic [7:0]             flag_evt,
  output logic                        busy
);

  ecx_state_t         s_q;
  ecx_state_t         s_d;
  ecx_cmd_t           cx;
  logic               bsy;
  logic               acc;
  logic               cy;
  logic               co;
  logic               ov;
  logic               sk;
  logic               sd;
  logic               sr;
  logic [7:0]         dv;
  logic [7:0]         rv;
  logic [7:0]         kv;
  logic [7:0]         res;
  logic [7:0]         ioa;
  logic [7:0]         iov;
  logic [7:0]         bm;
  logic [7:0]         rdi;
  logic [4:0]         hn;
  logic [4:0]         pl;
  logic [16:0]        w17;
  logic [15:0]        wv;
  logic [15:0]        zp;
  logic [15:0]        pcv;
  logic [15:0]        ret;
  logic signed [17:0] pr;
  logic [1:0]         resp;
  logic [3:0]         cyc;

  // ==========================================
  // data space store with write-one-to-clear flags
  function automatic ecx_state_t put(ecx_state_t s, logic [7:0] a, logic [7:0] v);
    if (a == `ECX_FLAG_DA) begin
      s.mem[a] = s.mem[a] & ~v;
    end else begin
      s.mem[a] = v;
    end
    return s;
  endfunction

  assign bsy     = (s_q.cnt != 4'h0);
  assign busy    = bsy;
  assign awready = !s_q.aw_ok && !s_q.bv;
  assign wready  = !s_q.w_ok && !s_q.bv;
  assign bvalid  = s_q.bv;
  assign bresp   = s_q.br;
  assign arready = !s_q.rv;
  assign rvalid  = s_q.rv;
  assign rdata   = s_q.rdat;
  assign rresp   = s_q.rr;

  // ==========================================
  // next state
  always_comb begin
    s_d  = s_q;
    cx   = ecx_cmd_t'(s_q.wd);
    acc  = 1'b0;
    resp = `ECX_RESP_OK;
    cy   = s_q.sreg[`ECX_SR_C];
    dv   = s_q.mem[cx.rd];
    rv   = s_q.mem[cx.rr];
    kv   = cx.imm;
    rdi  = {3'h0, cx.rd};
    ioa  = cx.imm + `ECX_IO_OFS;
    iov  = s_q.mem[ioa];
    bm   = 8'h01 << cx.bsel;
    zp   = {s_q.mem[`ECX_ZH], s_q.mem[`ECX_ZL]};
    pcv  = s_q.pc;
    res  = 8'h00;
    co   = 1'b0;
    ov   = 1'b0;
    sk   = 1'b0;
    sd   = 1'b0;
    sr   = 1'b0;
    hn   = 5'h00;
    w17  = 17'h00000;
    wv   = 16'h0000;
    ret  = 16'h0000;
    pr   = 18'sh00000;
    pl   = {`ECX_PAIR_HI, cx.rd[2:1], 1'b0};
    cyc  = `ECX_T_ALU;
    if (bsy) begin
      s_d.cnt = s_q.cnt - 4'h1;
    end
    if (awvalid && awready) begin
      s_d.aw_ok = 1'b1;
      s_d.awa   = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_ok = 1'b1;
      s_d.wd   = wdata;
      s_d.ws0  = wstrb[0];
    end
    if (s_q.bv && bready) begin
      s_d.bv = 1'b0;
    end
    if (s_q.aw_ok && s_q.w_ok) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok  = 1'b0;
      s_d.bv    = 1'b1;
      if (s_q.awa == `ECX_CMD_OFS && !bsy) begin
        acc = 1'b1;
      end else if (s_q.awa == `ECX_PC_OFS && !bsy) begin
        s_d.pc = s_q.wd[15:0];
      end else if (s_q.awa[11:10] == `ECX_DATA_SEL && s_q.awa[1:0] == 2'h0 && !bsy) begin
        if (s_q.ws0) begin
          s_d = put(s_d, s_q.awa[9:2], s_q.wd[7:0]);
        end
      end else begin
        resp = `ECX_RESP_ERR;
      end
      s_d.br = resp;
    end
    // ==========================================
    // execute
    if (acc) begin
      s_d.cmd  = s_q.wd;
      s_d.err  = 1'b0;
      s_d.skip = 1'b0;
      s_d.pc   = s_q.pc + `ECX_PC_STEP;
      case (cx.op)
        op_nop: begin
        end
        op_add_with_carry: begin
          {co, res} = {1'b0, dv} + {1'b0, rv} + {8'h00, cy};
          hn = {1'b0, dv[3:0]} + {1'b0, rv[3:0]} + {4'h0, cy};
          ov = (dv[7] & rv[7] & ~res[7]) | (~dv[7] & ~rv[7] & res[7]);
          s_d.mem[cx.rd] = res;
          s_d.sreg[`ECX_SR_C] = co;
          s_d.sreg[`ECX_SR_Z] = (res == 8'h00);
          s_d.sreg[`ECX_SR_N] = res[7];
          s_d.sreg[`ECX_SR_V] = ov;
          s_d.sreg[`ECX_SR_H] = hn[4];
        end
        op_sub_with_borrow, op_sub_constant, op_sub_borrow_constant: begin
          if (cx.op == op_sub_with_borrow) begin
            kv = rv;
          end
          if (cx.op == op_sub_constant) begin
            cy = 1'b0;
          end
          {co, res} = {1'b0, dv} - {1'b0, kv} - {8'h00, cy};
          hn = {1'b0, dv[3:0]} - {1'b0, kv[3:0]} - {4'h0, cy};
          ov = (dv[7] & ~kv[7] & ~res[7]) | (~dv[7] & kv[7] & res[7]);
          s_d.mem[cx.rd] = res;
          s_d.sreg[`ECX_SR_C] = co;
          s_d.sreg[`ECX_SR_Z] = (res == 8'h00);
          s_d.sreg[`ECX_SR_N] = res[7];
          s_d.sreg[`ECX_SR_V] = ov;
          s_d.sreg[`ECX_SR_H] = hn[4];
        end
        op_word_sum_immediate, op_word_sub_immediate: begin
          wv = {s_q.mem[{pl[4:1], 1'b1}], s_q.mem[pl]};
          if (cx.op == op_word_sum_immediate) begin
            w17 = {1'b0, wv} + {11'h000, cx.imm[5:0]};
            ov  = ~wv[15] & w17[15];
          end else begin
            w17 = {1'b0, wv} - {11'h000, cx.imm[5:0]};
            ov  = wv[15] & ~w17[15];
          end
          s_d.mem[{pl[4:1], 1'b1}] = w17[15:8];
          s_d.mem[pl] = w17[7:0];
          s_d.sreg[`ECX_SR_C] = w17[16];
          s_d.sreg[`ECX_SR_Z] = (w17[15:0] == 16'h0000);
          s_d.sreg[`ECX_SR_N] = w17[15];
          s_d.sreg[`ECX_SR_V] = ov;
          s_d.sreg[`ECX_SR_S] = w17[15] ^ ov;
          cyc = `ECX_T_WORD;
        end
        op_conj_constant, op_disj_constant, op_bits_set_mask, op_bits_clear_mask,
        op_zero_minus_test: begin
          case (cx.op)
            op_conj_constant:   res = dv & kv;
            op_bits_clear_mask: res = dv & (`ECX_ALL_ONES - kv);
            op_zero_minus_test: res = dv & dv;
            default:            res = dv | kv;
          endcase
          if (cx.op != op_zero_minus_test) begin
            s_d.mem[cx.rd] = res;
          end
          s_d.sreg[`ECX_SR_Z] = (res == 8'h00);
          s_d.sreg[`ECX_SR_N] = res[7];
          s_d.sreg[`ECX_SR_V] = 1'b0;
        end
        op_product_unsigned, op_product_signed, op_product_mixed,
        op_fractional_product_unsigned, op_fractional_product_signed,
        op_fractional_product_mixed: begin
          sd = cx.op inside {op_product_signed, op_product_mixed,
                             op_fractional_product_signed, op_fractional_product_mixed};
          sr = cx.op inside {op_product_signed, op_fractional_product_signed};
          pr = $signed({sd & dv[7], dv}) * $signed({sr & rv[7], rv});
          wv = pr[15:0];
          if (cx.op inside {op_fractional_product_unsigned, op_fractional_product_signed,
                            op_fractional_product_mixed}) begin
            wv = {pr[14:0], 1'b0};
          end
          s_d.mem[`ECX_R1] = wv[15:8];
          s_d.mem[`ECX_R0] = wv[7:0];
          s_d.sreg[`ECX_SR_C] = pr[15];
          s_d.sreg[`ECX_SR_Z] = (wv == 16'h0000);
          cyc = `ECX_T_MUL;
        end
        op_jump_via_z: begin
          s_d.pc = zp;
          cyc = `ECX_T_JUMP_VIA_Z;
        end
        op_subroutine_via_z: begin
          ret = s_q.pc + `ECX_PC_STEP;
          s_d = put(s_d, s_q.sp, ret[7:0]);
          s_d = put(s_d, s_q.sp - 8'h01, ret[15:8]);
          s_d.sp = s_q.sp - `ECX_SP_STEP;
          s_d.pc = zp;
          cyc = `ECX_T_SUBROUTINE_VIA_Z;
        end
        op_compare_skip_equal: begin
          sk = (dv == rv);
        end
        op_io_bit_set, op_io_bit_clear, op_skip_io_bit_high, op_skip_io_bit_low: begin
          if (cx.imm > `ECX_BITIO_MAX) begin
            s_d.err = 1'b1;
          end else if (cx.op == op_skip_io_bit_high) begin
            sk = iov[cx.bsel];
          end else if (cx.op == op_skip_io_bit_low) begin
            sk = !iov[cx.bsel];
          end else if (cx.op == op_io_bit_set) begin
            s_d = put(s_d, ioa, (ioa == `ECX_FLAG_DA) ? bm : (iov | bm));
          end else if (ioa != `ECX_FLAG_DA) begin
            s_d = put(s_d, ioa, iov & ~bm);
          end
          if (cx.op inside {op_io_bit_set, op_io_bit_clear}) begin
            cyc = `ECX_T_BITOP;
          end
        end
        op_port_read, op_port_write: begin
          if (cx.imm > `ECX_PORT_MAX) begin
            s_d.err = 1'b1;
          end else if (cx.op == op_port_read) begin
            s_d.mem[cx.rd] = iov;
          end else begin
            s_d = put(s_d, ioa, dv);
          end
        end
        op_read_mem_direct: begin
          s_d.mem[cx.rd] = s_q.mem[cx.imm];
          cyc = `ECX_T_LDST;
        end
        op_write_mem_direct: begin
          s_d = put(s_d, cx.imm, dv);
          cyc = `ECX_T_LDST;
        end
        default: begin
          s_d.err = 1'b1;
        end
      endcase
      if (sk) begin
        s_d.skip = 1'b1;
        s_d.pc   = s_q.pc + (cx.long_next ? `ECX_PC_SKIPL : `ECX_PC_SKIPS);
        cyc      = cx.long_next ? `ECX_T_SKIPL : `ECX_T_SKIPS;
      end
      s_d.cnt = cyc;
    end
    // event set wins over a same-cycle clear
    s_d.mem[`ECX_FLAG_DA] = s_d.mem[`ECX_FLAG_DA] | flag_evt;
    // ==========================================
    // register read
    if (s_q.rv && rready) begin
      s_d.rv = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rv = 1'b1;
      s_d.rr = `ECX_RESP_OK;
      if (araddr == `ECX_CMD_OFS) begin
        s_d.rdat = s_q.cmd;
      end else if (araddr == `ECX_STAT_OFS) begin
        s_d.rdat = {8'h00, s_q.sp, s_q.sreg, 5'h00, s_q.err, s_q.skip, bsy};
      end else if (araddr == `ECX_PC_OFS) begin
        s_d.rdat = {16'h0000, s_q.pc};
      end else if (araddr[11:10] == `ECX_DATA_SEL && araddr[1:0] == 2'h0) begin
        s_d.rdat = {24'h000000, s_q.mem[araddr[9:2]]};
      end else begin
        s_d.rdat = 32'h00000000;
        s_d.rr   = `ECX_RESP_ERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q    <= '0;
      s_q.sp <= `ECX_SP_RST;
      s_q.pc <= `ECX_PC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // checks
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence busy_one;
    bsy ##1 !bsy;
  endsequence
  sequence busy_two;
    bsy [*2] ##1 !bsy;
  endsequence
  sequence busy_three;
    bsy [*3] ##1 !bsy;
  endsequence

  chk_bit_range: assert property (
    acc && cx.op inside {op_io_bit_set, op_io_bit_clear} && cx.imm > `ECX_BITIO_MAX
    |=> s_q.err && s_q.mem[$past(ioa)] == $past(iov))
    else $error("bit op above low io range took effect");
  chk_bit_isolate: assert property (
    acc && cx.op == op_io_bit_set && cx.imm <= `ECX_BITIO_MAX && ioa != `ECX_FLAG_DA
    |=> s_q.mem[$past(ioa)] == ($past(iov) | $past(bm)))
    else $error("io bit set disturbed other bits");
  chk_flag_w1c: assert property (
    acc && cx.op == op_port_write && ioa == `ECX_FLAG_DA && flag_evt == 8'h00
    |=> s_q.mem[`ECX_FLAG_DA] == ($past(iov) & ~$past(dv)))
    else $error("written ones did not clear flags");
  chk_port_map: assert property (
    acc && cx.op == op_port_read && cx.imm <= `ECX_PORT_MAX
    |=> s_q.mem[$past(rdi)] == $past(iov) ##0 busy_one)
    else $error("port read used wrong data address");
  chk_port_ext: assert property (
    acc && cx.op inside {op_port_read, op_port_write} && cx.imm > `ECX_PORT_MAX |=> s_q.err)
    else $error("port op reached beyond io range");
  chk_adc_sum: assert property (
    acc && cx.op == op_add_with_carry
    |=> s_q.mem[$past(rdi)] == 8'($past(dv) + $past(rv) + 8'($past(cy))) ##0 busy_one)
    else $error("add with carry result or time wrong");
  chk_half_carry: assert property (
    acc && cx.op == op_add_with_carry
    |=> s_q.sreg[`ECX_SR_H] == ((5'($past(dv) & 8'h0F) + 5'($past(rv) & 8'h0F) + 5'($past(cy))) > 5'h0F))
    else $error("half carry wrong");
  chk_word_time: assert property (
    acc && cx.op inside {op_word_sum_immediate, op_word_sub_immediate} |=> busy_two)
    else $error("word op not two clocks");
  chk_mul_prod: assert property (
    acc && cx.op == op_product_unsigned
    |=> {s_q.mem[`ECX_R1], s_q.mem[`ECX_R0]} == $past(dv) * $past(rv) ##0 busy_two)
    else $error("unsigned product wrong");
  chk_subroutine_via_z_pc: assert property (
    acc && cx.op == op_subroutine_via_z |=> s_q.pc == $past(zp) ##0 busy_three)
    else $error("indirect call target or time wrong");
  chk_skip_step: assert property (
    acc && cx.op == op_compare_skip_equal && dv == rv && !cx.long_next
    |=> s_q.pc == $past(pcv) + `ECX_PC_SKIPS ##0 busy_two)
    else $error("skip did not step pc by two");

endmodule

// file: test/ecx_core_tb.sv
// self-checking bench of the execute core
`timescale 1ns/10ps
module ecx_core_tb
  import ecx_pkg::*;
;
  typedef struct packed {logic [31:0] m; logic [31:0] d; logic [1:0] r;} ecx_exp_t;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, fire;
  logic        awready, wready, bvalid, arready, rvalid, busy, c, sb, h, v;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, p;
  logic [7:0]  fbits, flag_evt, esr, esp, a, b, r, k;
  logic [8:0]  s;
  logic [15:0] w, q;
  logic [16:0] x;
  int          error_cnt, comparisons, bcnt, cyc;
  ecx_exp_t    exp_q[$];
  logic [3:0]  busy_q[$];
  ecx_op_t     aop[4] = '{op_add_with_carry, op_sub_with_borrow, op_sub_constant, op_sub_borrow_constant};
  ecx_op_t     lop[5] = '{op_conj_constant, op_disj_constant, op_bits_set_mask, op_bits_clear_mask,
                          op_zero_minus_test};

  ecx_core DUT (.clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .flag_evt, .busy);
  ecx_evt_model EVT (.clk, .fire, .bits(fbits), .flag_evt);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================
  // reporting
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================
  // result watcher, oldest note first
  always @(posedge clk) begin
    ecx_exp_t e;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = exp_q.pop_front();
      check("rdata", rdata & e.m, e.d & e.m);
      check("rresp", {30'h0, rresp}, {30'h0, e.r});
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      e = exp_q.pop_front();
      check("bresp", {30'h0, bresp}, {30'h0, e.r});
    end
    if (busy === 1'b1) begin
      bcnt++;
    end else if (bcnt != 0) begin
      check("busy cycles", 32'(bcnt), {28'h0, busy_q.pop_front()});
      bcnt = 0;
    end
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      final_report();
    end
  end

  // ==========================================
  // axi4-lite master
  task automatic wr(logic [11:0] ad, logic [31:0] d, logic [1:0] rs = 2'h0);
    exp_q.push_back('{32'h0, 32'h0, rs});
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= ad;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(logic [11:0] ad, logic [31:0] m, logic [31:0] d, logic [1:0] rs = 2'h0);
    exp_q.push_back('{m, d, rs});
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= ad;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic setb(int ad, logic [7:0] d);
    wr(12'h400 + 12'(ad * 4), {24'h0, d});
  endtask

  task automatic getb(int ad, logic [7:0] d);
    rd(12'h400 + 12'(ad * 4), 32'hFF, {24'h0, d});
  endtask

  task automatic stat();
    rd(12'h004, 32'h00FF_FF00, {8'h0, esp, esr, 8'h0});
  endtask

  task automatic exec(ecx_op_t op, int d, int rr, logic [7:0] kk, logic [3:0] n, logic [2:0] bs = 3'h0,
                      logic lg = 1'b0);
    busy_q.push_back(n);
    wr(12'h000, ecx_cmd_t'{kk, 2'h0, lg, 5'(rr), 3'h0, 5'(d), bs, op});
    do @(posedge clk); while (busy === 1'b1);
  endtask

  // ==========================================
  // main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, fire} = '0;
    {awaddr, araddr, wdata, wstrb, fbits} = '0;
    {error_cnt, comparisons, bcnt, cyc} = '0;
    esr = 8'h00;
    esp = 8'hFF;
    void'($urandom(82283));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wstrb <= 4'hF;
    stat();
    for (int i = 0; i < 4; i++) begin
      repeat (3) begin
        a = 8'($urandom);
        b = 8'($urandom);
        c = (aop[i] == op_sub_constant) ? 1'b0 : esr[0];
        sb = (aop[i] != op_add_with_carry);
        s = sb ? {1'b0, a} - {1'b0, b} - 9'(c) : {1'b0, a} + {1'b0, b} + 9'(c);
        h = sb ? {1'b0, a[3:0]} < {1'b0, b[3:0]} + 5'(c) : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(c) > 5'h0F;
        v = sb ? (a[7] ^ b[7]) & (s[7] ^ a[7]) : ~(a[7] ^ b[7]) & (s[7] ^ a[7]);
        esr[5] = h;
        esr[3:0] = {v, s[7], s[7:0] == 8'h00, s[8]};
        setb(16, a);
        setb(17, b);
        exec(aop[i], 16, 17, b, 4'h1);
        getb(16, s[7:0]);
        stat();
      end
    end
    $display("test add and subtract done");
    for (int i = 0; i < 5; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      case (i)
        0: r = a & b;
        1, 2: r = a | b;
        3: r = a & (8'hFF - b);
        default: r = a;
      endcase
      esr[3:1] = {1'b0, r[7], r == 8'h00};
      setb(16, a);
      exec(lop[i], 16, 17, b, 4'h1);
      getb(16, r);
      stat();
    end
    $display("test logic done");
    for (int i = 0; i < 2; i++) begin
      repeat (3) begin
        p = 2'($urandom);
        w = 16'($urandom);
        k = 8'($urandom);
        x = i ? {1'b0, w} - 17'(k[5:0]) : {1'b0, w} + 17'(k[5:0]);
        v = i ? w[15] & ~x[15] : ~w[15] & x[15];
        esr[4:0] = {x[15] ^ v, v, x[15], x[15:0] == 16'h0, x[16]};
        setb(24 + 2 * p, w[7:0]);
        setb(25 + 2 * p, w[15:8]);
        exec(i ? op_word_sub_immediate : op_word_sum_immediate, 2 * p, 0, k, 4'h2);
        getb(24 + 2 * p, x[7:0]);
        getb(25 + 2 * p, x[15:8]);
        stat();
      end
    end
    $display("test word ops done");
    for (int i = 12; i < 18; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      case (i % 3)
        0: q = a * b;
        1: q = $signed(a) * $signed(b);
        default: q = $signed(a) * $signed({1'b0, b});
      endcase
      esr[0] = q[15];
      if (i > 14) q = q << 1;
      esr[1] = q == 16'h0;
      setb(16, a);
      setb(17, b);
      exec(ecx_op_t'(i), 16, 17, 8'h00, 4'h2);
      getb(0, q[7:0]);
      getb(1, q[15:8]);
      stat();
    end
    $display("test multiply done");
    w = 16'($urandom);
    setb(30, w[7:0]);
    setb(31, w[15:8]);
    wr(12'h008, 32'h0123);
    exec(op_jump_via_z, 0, 0, 8'h00, 4'h2);
    rd(12'h008, 32'hFFFF, {16'h0, w});
    wr(12'h008, 32'h0123);
    exec(op_subroutine_via_z, 0, 0, 8'h00, 4'h3);
    esp = 8'hFD;
    rd(12'h008, 32'hFFFF, {16'h0, w});
    getb(8'hFF, 8'h24);
    getb(8'hFE, 8'h01);
    for (int i = 0; i < 3; i++) begin
      a = 8'($urandom);
      setb(16, a);
      setb(17, i == 2 ? ~a : a);
      wr(12'h008, 32'h0040);
      exec(op_compare_skip_equal, 16, 17, 8'h00, i == 2 ? 4'h1 : 4'(2 + i), 3'h0, i == 1);
      rd(12'h008, 32'hFFFF, i == 2 ? 32'h41 : 32'(8'h42 + i));
    end
    stat();
    $display("test jump and skip done");
    // only bit-addressable and port addresses are written
    setb(8'h25, 8'hA0);
    setb(8'h40, 8'h5A);
    exec(op_io_bit_set, 0, 0, 8'h05, 4'h2, 3'h3);
    getb(8'h25, 8'hA8);
    exec(op_io_bit_clear, 0, 0, 8'h05, 4'h2, 3'h7);
    getb(8'h25, 8'h28);
    wr(12'h008, 32'h0040);
    exec(op_skip_io_bit_high, 0, 0, 8'h05, 4'h2, 3'h3);
    rd(12'h008, 32'hFFFF, 32'h42);
    wr(12'h008, 32'h0040);
    exec(op_skip_io_bit_low, 0, 0, 8'h05, 4'h1, 3'h3);
    rd(12'h008, 32'hFFFF, 32'h41);
    exec(op_io_bit_set, 0, 0, 8'h20, 4'h2);
    rd(12'h004, 32'h4, 32'h4);
    getb(8'h40, 8'h5A);
    fbits <= 8'h11;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    getb(8'h36, 8'h11);
    exec(op_io_bit_set, 0, 0, 8'h16, 4'h2);
    getb(8'h36, 8'h10);
    $display("test io bits done");
    setb(16, 8'h77);
    exec(op_port_write, 16, 0, 8'h3F, 4'h1);
    getb(8'h5F, 8'h77);
    exec(op_port_write, 16, 0, 8'h16, 4'h1);
    getb(8'h36, 8'h00);
    exec(op_port_read, 17, 0, 8'h05, 4'h1);
    getb(17, 8'h28);
    exec(op_port_write, 16, 0, 8'h40, 4'h1);
    rd(12'h004, 32'h4, 32'h4);
    exec(op_write_mem_direct, 16, 0, 8'h60, 4'h2);
    getb(8'h60, 8'h77);
    exec(op_read_mem_direct, 18, 0, 8'h5F, 4'h2);
    getb(18, 8'h77);
    rd(12'h00C, 32'hFFFF_FFFF, 32'h0, 2'h2);
    wr(12'h00C, 32'h0, 2'h2);
    exec(op_nop, 0, 0, 8'h00, 4'h1);
    $display("test ports done");
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule

// file: test/ecx_evt_model.sv
// status event source standing beside the execute core
`timescale 1ns/10ps
module ecx_evt_model (
  // clock
  input  wire logic       clk,
  // event request from the bench
  input  wire logic       fire,
  input  wire logic [7:0] bits,
  // status events toward the core
  output logic [7:0]      flag_evt
);
  // ==========================================
  // one-cycle pulse per request, quiet between
  always_ff @(posedge clk) begin
    flag_evt <= fire ? bits : 8'h00;
  end
endmodule
